/* hw/fault_seq_pkg.sv */
package fault_seq_pkg;

   // Clock rate and derived cycle counts
   localparam int unsigned CLK_PERIOD_PS = 4000;
   localparam int unsigned OPP_TIME_MS   = 160;
   localparam int unsigned FDR_TIME_MS   = 1500;
   localparam int unsigned HVG_TIME_NS   = 10000;
   localparam int unsigned ONT_LONG_NS   = 2000;
   localparam int unsigned ONT_SHORT_NS  = 1000;
   localparam int unsigned OPP_CYCLES    = 32'((OPP_TIME_MS * 64'd1000000000) / CLK_PERIOD_PS);
   localparam int unsigned FDR_CYCLES    = 32'((FDR_TIME_MS * 64'd1000000000) / CLK_PERIOD_PS);
   localparam int unsigned HVG_CYCLES    = (HVG_TIME_NS * 1000) / CLK_PERIOD_PS;
   localparam int unsigned ONT_LONG_CYC  = (ONT_LONG_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int unsigned ONT_SHORT_CYC = (ONT_SHORT_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int unsigned OCP_PULSES    = 3;

   localparam int TMR_W = 32;

   // Sequencer states, one-hot
   typedef enum logic [4:0] {
      ST_OFF     = 5'b0_0001,
      ST_CHECK   = 5'b0_0010,
      ST_RUN     = 5'b0_0100,
      ST_RECOVER = 5'b0_1000,
      ST_WAITOFF = 5'b1_0000
   } seq_state_type;

   // Comparator results from the power stage
   typedef struct packed {
      logic supply_on;       // Supply reached turn-on level
      logic supply_off;      // Supply fell to turn-off threshold
      logic cs_above_opp;    // Current sense above over-power curve
      logic cs_above_ocp;    // Current sense above 1.2 V level
      logic cs_at_ceiling;   // Current sense at 0.8 V ceiling
      logic aux_below_min;   // Aux winding sense below 0.6 V
      logic hvg_above_low;   // High-side gate supply above 12 V
      logic hvg_above_high;  // High-side gate supply above 14 V
      logic over_temp;       // Junction over-temperature flag
      logic pin_fault;       // Program pin short or open
      logic cfg_high;        // Configuration pin high
      logic rdm_large;       // Program resistor at least 55 kOhm
      logic blank_done;      // Leading-edge blanking elapsed
      logic demag_done;      // Demagnetization ended
   } sense_type;

endpackage

/* hw/fault_seq.sv */
`timescale 1ns/100ps
`default_nettype none

////////////////////////////////////////////////////////////////////////////////
// How it works
// - Gate turns off whenever sense reaches the 0.8 V ceiling.
// - Over-power timer counts while sense is above the over-power curve.
// - Uninterrupted 160 ms over-power stops switching and starts 1.5 s recovery.
// - At supply turn-off, over-power or aux below 0.6 V means short circuit.
// - Short circuit starts the 1.5 s recovery at once.
// - Three consecutive over-current gate cycles stop switching, drop run, recover.
// - During recovery no gate pulses are issued; only lockout cycling.
// - After recovery, normal start follows the next supply turn-off.
// - Over-temperature forces a lockout reset and restart cycle.
// - Over-temperature still set at the next turn-on repeats the protection cycle.
// - First pulse on-time over 2 us or 1 us forces lockout reset.
// - Gate supply not above 12 V after 10 us, or above 14 V, resets.
module fault_seq
   import fault_seq_pkg::*;
(
   input  wire logic      clock_i,        // 250 MHz clock
   input  wire logic      rst_n_i,        // Async reset, active low
   input  wire sense_type sense_i,        // Comparator results (asynchronous)
   input  wire logic      pulse_req_i,    // Loop requests low-side pulse (same clock)
   output logic           low_side_gate_pulse_o, // Gated low-side pulse
   output logic           run_o,          // Run enable
   output logic           lockout_req_o,  // Request lockout reset, level
   output logic           fault_wait_o    // Long recovery in progress
);

   ////////////////////////////////////////////////////////////////////////////////
   // Reset release synchroniser
   // Assertion is immediate; release waits two edges so no flop sees a runt release
   logic rst_s1_r;                        // First release stage
   logic rst_s2_r;                        // Second release stage, feeds the internal reset
   always_ff @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         rst_s1_r <= 1'b0;
         rst_s2_r <= 1'b0;
      end else begin
         rst_s1_r <= 1'b1;
         rst_s2_r <= rst_s1_r;
      end
   end
   wire logic rst_n = rst_s2_r;

   ////////////////////////////////////////////////////////////////////////////////
   // Three-stage input synchroniser; a change counts when stages 2 and 3 agree
   // Stages reset low, the idle level of the supply comparators, so no false edge follows reset
   localparam int SW = $bits(sense_type);
   logic [SW-1:0] s1_r;                   // First capture stage, may go metastable
   logic [SW-1:0] s2_r;                   // Second stage
   logic [SW-1:0] s3_r;                   // Third stage
   logic [SW-1:0] sen_r;                  // Qualified comparator levels
   genvar g;
   generate
      for (g = 0; g < SW; g++) begin : g_sync
         always_ff @(posedge clock_i or negedge rst_n) begin
            if (!rst_n) begin
               s1_r[g]  <= 1'b0;
               s2_r[g]  <= 1'b0;
               s3_r[g]  <= 1'b0;
               sen_r[g] <= 1'b0;
            end else begin
               s1_r[g] <= sense_i[g];
               s2_r[g] <= s1_r[g];
               s3_r[g] <= s2_r[g];
               if (s2_r[g] == s3_r[g]) begin
                  sen_r[g] <= s3_r[g];
               end
            end
         end
      end
   endgenerate
   sense_type sen;
   assign sen = sense_type'(sen_r);

   ////////////////////////////////////////////////////////////////////////////////
   // State and counters
   seq_state_type    state_r;             // Sequencer state
   seq_state_type    state_nxt;           // Next sequencer state
   logic [TMR_W-1:0] opp_cnt_r;           // Over-power persistence timer
   logic [TMR_W-1:0] fdr_cnt_r;           // Long recovery timer
   logic [TMR_W-1:0] chk_cnt_r;           // Turn-on gate supply window
   logic [TMR_W-1:0] ont_cnt_r;           // First-pulse on-time
   logic [1:0]       ocp_run_r;           // Consecutive over-current pulses
   logic             first_r;             // No pulse has ended since entering run
   logic             ocp_seen_r;          // Over-current seen in the current pulse
   logic             gate_r;              // Registered gate
   logic             run_r;               // Registered run enable
   logic             lock_r;              // Registered lockout request
   logic             ceil_cut_r;          // Pulse cut by the ceiling until the request drops
   logic             supply_off_d_r;      // Turn-off comparator, last cycle
   logic             supply_on_d_r;       // Turn-on comparator, last cycle

   // Edges of supply level comparators
   // Levels are compared with their last value; only rising edges are events
   wire logic off_edge  = sen.supply_off & ~supply_off_d_r;
   wire logic on_edge   = sen.supply_on & ~supply_on_d_r;

   // Pulse gating: ceiling ends the pulse in the same cycle it is seen, and the
   // cut holds until the loop drops its request, so one request makes one pulse
   wire logic gate_ok   = (state_r == ST_RUN) & ~lock_r;
   wire logic ceil_hit  = gate_r & pulse_req_i & sen.cs_at_ceiling;
   wire logic gate_nxt  = gate_ok & pulse_req_i & ~sen.cs_at_ceiling & ~ceil_cut_r;
   wire logic pulse_end = gate_r & ~gate_nxt;

   // On-time limit for the first pulse; longer limit when cfg high or resistor large
   // Counted in whole cycles, so a pulse is cut one cycle past the limit
   wire logic [TMR_W-1:0] ont_lim = (sen.cfg_high | sen.rdm_large) ?
                                     TMR_W'(ONT_LONG_CYC) : TMR_W'(ONT_SHORT_CYC);
   wire logic ont_fault = first_r & gate_r & (ont_cnt_r >= ont_lim);

   // Over-current seen inside the sensing window of a pulse cycle
   wire logic ocp_window = sen.blank_done & ~sen.demag_done;
   wire logic ocp_trip   = pulse_end & (ocp_run_r == 2'(OCP_PULSES - 1))
                           & (ocp_seen_r | (ocp_window & sen.cs_above_ocp));

   // Over-power timer expiry: condition held without break
   wire logic opp_trip   = (opp_cnt_r >= TMR_W'(OPP_CYCLES - 1)) & sen.cs_above_opp;

   // Short circuit check at supply turn-off
   // Judged only in run; a turn-off in run without a short is a plain lockout
   wire logic scp_trip   = off_edge & (sen.cs_above_opp | sen.aux_below_min);

   // Gate supply checks after turn-on
   // The low check is made once, at the end of the settle window
   wire logic hvg_fault  = sen.hvg_above_high
                           | ((state_r == ST_CHECK) & (chk_cnt_r >= TMR_W'(HVG_CYCLES))
                              & ~sen.hvg_above_low);

   // Immediate lockout resets
   wire logic lock_now   = sen.over_temp | hvg_fault | ont_fault
                           | ((state_r == ST_CHECK) & sen.pin_fault);

   // Faults that need the long recovery rather than a plain lockout
   wire logic long_fault = (state_r == ST_RUN) & (opp_trip | ocp_trip | scp_trip);

   // Recovery ends after the full count
   wire logic fdr_done   = fdr_cnt_r >= TMR_W'(FDR_CYCLES - 1);

   ////////////////////////////////////////////////////////////////////////////////
   // Sequencer next state
   always_comb begin
      state_nxt = state_r;
      unique case (state_r)
         ST_OFF: begin
            // Over-temperature still set at turn-on starts another lockout cycle
            if (on_edge & sen.over_temp) begin
               state_nxt = ST_WAITOFF;
            end else if (on_edge) begin
               state_nxt = ST_CHECK;
            end
         end
         ST_CHECK: begin
            // Pin and gate supply faults are judged inside the turn-on window
            if (lock_now) begin
               state_nxt = ST_WAITOFF;
            end else if (chk_cnt_r >= TMR_W'(HVG_CYCLES)) begin
               state_nxt = ST_RUN;
            end
         end
         ST_RUN: begin
            // Long faults win over plain lockouts so recovery is never skipped
            if (long_fault) begin
               state_nxt = ST_RECOVER;
            end else if (lock_now | off_edge) begin
               state_nxt = ST_WAITOFF;
            end
         end
         ST_RECOVER: begin
            // Turn-off edges are ignored here: only the lockout cycle runs
            if (fdr_done) begin
               state_nxt = ST_WAITOFF;
            end
         end
         ST_WAITOFF: begin
            // The next turn-off edge ends the lockout cycle
            if (off_edge) begin
               state_nxt = ST_OFF;
            end
         end
         default: state_nxt = ST_WAITOFF;
      endcase
   end

   ////////////////////////////////////////////////////////////////////////////////
   // State, edge history and outputs
   always_ff @(posedge clock_i or negedge rst_n) begin
      if (!rst_n) begin
         state_r        <= ST_OFF;
         supply_off_d_r <= 1'b0;
         supply_on_d_r  <= 1'b0;
         gate_r         <= 1'b0;
         run_r          <= 1'b0;
         lock_r         <= 1'b0;
      end else begin
         state_r        <= state_nxt;
         supply_off_d_r <= sen.supply_off;
         supply_on_d_r  <= sen.supply_on;
         gate_r         <= gate_nxt & (state_nxt == ST_RUN);
         run_r          <= (state_nxt == ST_RUN);
         lock_r         <= (state_nxt == ST_WAITOFF) | (state_nxt == ST_RECOVER);
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // 32-bit timers hold the 1.5 s recovery, which needs 29 bits at 250 MHz
   // Over-power timer: clears on any break in the condition
   always_ff @(posedge clock_i or negedge rst_n) begin
      if (!rst_n) begin
         opp_cnt_r <= '0;
      end else if ((state_r == ST_RUN) & sen.cs_above_opp & ~opp_trip) begin
         opp_cnt_r <= opp_cnt_r + 1'b1;
      end else begin
         opp_cnt_r <= '0;
      end
   end

   // Recovery timer runs only in the long fault wait; no pulses meanwhile
   always_ff @(posedge clock_i or negedge rst_n) begin
      if (!rst_n) begin
         fdr_cnt_r <= '0;
      end else if (state_r == ST_RECOVER) begin
         fdr_cnt_r <= fdr_cnt_r + 1'b1;
      end else begin
         fdr_cnt_r <= '0;
      end
   end

   // Turn-on check timer for the gate supply settle window
   always_ff @(posedge clock_i or negedge rst_n) begin
      if (!rst_n) begin
         chk_cnt_r <= '0;
      end else if (state_r == ST_CHECK) begin
         chk_cnt_r <= chk_cnt_r + 1'b1;
      end else begin
         chk_cnt_r <= '0;
      end
   end

   // Ceiling cut latch; without it the falling sense would restart the gate
   // within one request and the peak would be reached again and again
   always_ff @(posedge clock_i or negedge rst_n) begin
      if (!rst_n) begin
         ceil_cut_r <= 1'b0;
      end else if (ceil_hit) begin
         ceil_cut_r <= 1'b1;
      end else if (!pulse_req_i) begin
         ceil_cut_r <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Pulse bookkeeping: first-pulse on-time and consecutive over-current run
   // Only the first pulse after entering run is timed; later pulses are free
   always_ff @(posedge clock_i or negedge rst_n) begin
      if (!rst_n) begin
         ont_cnt_r  <= '0;
         first_r    <= 1'b1;
         ocp_seen_r <= 1'b0;
         ocp_run_r  <= '0;
      end else if (state_r != ST_RUN) begin
         ont_cnt_r  <= '0;
         first_r    <= 1'b1;
         ocp_seen_r <= 1'b0;
         ocp_run_r  <= '0;
      end else begin
         ont_cnt_r <= gate_r ? ont_cnt_r + 1'b1 : '0;
         if (pulse_end) begin
            first_r    <= 1'b0;
            ocp_seen_r <= 1'b0;
            // A clean cycle breaks the consecutive run
            if (ocp_seen_r | (ocp_window & sen.cs_above_ocp)) begin
               ocp_run_r <= (ocp_run_r == 2'(OCP_PULSES - 1)) ? '0 : ocp_run_r + 1'b1;
            end else begin
               ocp_run_r <= '0;
            end
         end else if (gate_r & ocp_window & sen.cs_above_ocp) begin
            ocp_seen_r <= 1'b1;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Outputs, each straight from its flip-flop
   assign low_side_gate_pulse_o = gate_r;
   assign run_o                 = run_r;
   assign lockout_req_o         = lock_r;

   // Recovery flag registered so the output comes straight from a flip-flop
   logic fw_r;
   always_ff @(posedge clock_i or negedge rst_n) begin
      if (!rst_n) begin
         fw_r <= 1'b0;
      end else begin
         fw_r <= (state_nxt == ST_RECOVER);
      end
   end
   assign fault_wait_o = fw_r;

endmodule

`default_nettype wire

/* tb/fault_seq_props.sv */
`timescale 1ns/100ps
`default_nettype none
module fault_seq_props
   import fault_seq_pkg::*;
(
   input wire logic      clock_i,               // Clock
   input wire logic      rst_n_i,               // Reset, active low
   input wire sense_type sense_i,               // Comparator levels
   input wire logic      pulse_req_i,           // Pulse request
   input wire logic      low_side_gate_pulse_o, // Gate out
   input wire logic      run_o,                 // Run enable
   input wire logic      lockout_req_o,         // Lockout request
   input wire logic      fault_wait_o           // Long recovery
);
   // Windows allow for the three-flop input synchroniser
   default clocking cb @(posedge clock_i); endclocking
   default disable iff (!rst_n_i);
   AST_GATE_ONLY_ON_REQ: assert property
      (low_side_gate_pulse_o |-> $past(pulse_req_i) && !fault_wait_o) else $error("gate without request");
   AST_CEILING_CUT: assert property
      ($rose(sense_i.cs_at_ceiling) |-> ##[1:7] !low_side_gate_pulse_o) else $error("gate not cut");
   AST_WAIT_STOPS_RUN: assert property
      (fault_wait_o |-> !run_o && lockout_req_o) else $error("run during recovery");
   AST_WAIT_FROM_RUN: assert property
      ($rose(fault_wait_o) |-> $past(run_o)) else $error("recovery not from run");
   AST_WAIT_HOLDS: assert property
      ($rose(fault_wait_o) |=> fault_wait_o [*8]) else $error("recovery too short");
   AST_HOT_LOCKOUT: assert property
      ($rose(sense_i.over_temp) && run_o |-> ##[1:8] (lockout_req_o && !run_o)) else $error("no thermal lockout");
   AST_GATE_SUPPLY_HIGH: assert property
      ($rose(sense_i.hvg_above_high) && run_o |-> ##[1:8] (lockout_req_o && !run_o)) else $error("no supply lockout");
   AST_SHORT_CIRCUIT: assert property
      ($rose(sense_i.supply_off) && run_o && sense_i.aux_below_min |-> ##[1:8] fault_wait_o) else $error("short missed");
endmodule
bind fault_seq fault_seq_props i_props (.clock_i(clock_i), .rst_n_i(rst_n_i), .sense_i(sense_i),
   .pulse_req_i(pulse_req_i), .low_side_gate_pulse_o(low_side_gate_pulse_o), .run_o(run_o),
   .lockout_req_o(lockout_req_o), .fault_wait_o(fault_wait_o));
`default_nettype wire

/* tb/power_stage_model.sv */
`timescale 1ns/100ps
`default_nettype none
module power_stage_model (
   input  wire logic clock_i,      // Bench clock
   input  wire logic gate_i,       // Low-side gate pulse
   input  wire logic ocp_en_i,     // Pulses overshoot 1.2 V
   input  wire logic ceil_en_i,    // Pulses reach the ceiling
   output logic      blank_done_o, // Blanking over
   output logic      demag_done_o, // Demagnetization over
   output logic      ocp_o,        // Over-current comparator
   output logic      ceil_o        // Ceiling comparator
);
   logic [9:0] on_cnt;
   // Quiet stage until the first pulse
   initial begin
      on_cnt = 10'h000;
      {blank_done_o, demag_done_o, ocp_o, ceil_o} = 4'h4;
   end
   // Sense ramps while the gate is on and collapses when it opens
   always @(negedge clock_i) begin
      on_cnt       <= gate_i ? on_cnt + 10'h001 : 10'h000;
      blank_done_o <= gate_i && on_cnt >= 10'h004;
      demag_done_o <= !gate_i;
      ocp_o        <= ocp_en_i && gate_i && on_cnt >= 10'h004;
      ceil_o       <= ceil_en_i && gate_i && on_cnt >= 10'h010;
   end
endmodule
`default_nettype wire

/* tb/tb_fault_seq.sv */
`timescale 1ns/100ps
`default_nettype none
module tb_fault_seq;
   import fault_seq_pkg::*;
   typedef struct {logic [2:0] e; logic [2:0] m;} note_type;
   logic      clock, rst_n, req, ocp_en, ceil_en, gate, run, lock, fwait, blank, demag, over_current_protection, ceil;
   sense_type st, sns, b;
   note_type  notes[$];
   int        bad_count = 0;
   int        tests_run = 0;
   int        cyc = 0;
   int        lim;
   int        wid;
   int        last_on = 0;
   int        gate_cyc = 0;
   event      chk;
   // Bench sets the slow levels, the stage model the per-pulse ones
   always_comb begin
      sns = st;
      sns.blank_done = blank;
      sns.demag_done = demag;
      sns.cs_above_ocp = over_current_protection;
      sns.cs_at_ceiling = ceil;
   end
   fault_seq i_dut (.clock_i(clock), .rst_n_i(rst_n), .sense_i(sns), .pulse_req_i(req),
      .low_side_gate_pulse_o(gate), .run_o(run), .lockout_req_o(lock), .fault_wait_o(fwait));
   power_stage_model i_stage (.clock_i(clock), .gate_i(gate), .ocp_en_i(ocp_en), .ceil_en_i(ceil_en),
      .blank_done_o(blank), .demag_done_o(demag), .ocp_o(over_current_protection), .ceil_o(ceil));
   initial begin
      clock = 1'b0;
      forever #2 clock = ~clock;
   end
   // Longest run is about 52k cycles, so this only trips on a hang
   always @(posedge clock) begin
      cyc <= cyc + 1;
      if (cyc == 100000) begin
         bad_count++;
         finish_test();
      end
   end
   // Gate-high cycles, counted at the falling edge where the gate is settled
   always @(negedge clock) begin
      if (gate === 1'b1) gate_cyc <= gate_cyc + 1;
   end
   // Compare run, lockout and wait with the oldest posted note
   always @(chk) begin
      note_type n;
      n = notes.pop_front();
      tests_run++;
      if (({run, lock, fwait} & n.m) !== (n.e & n.m)) begin
         bad_count++;
         $display("wrong value run/lockout/wait: expected %b seen %b", n.e & n.m, {run, lock, fwait} & n.m);
      end
   end
   task automatic expect_out(input logic [2:0] e, input logic [2:0] m);
      notes.push_back('{e, m});
      ->chk;
   endtask
   // Reset, then raise supply and wait a bounded time for run
   task automatic start_up(input sense_type s);
      rst_n = 1'b0;
      st = s;
      repeat (20) @(negedge clock);
      rst_n = 1'b1;
      repeat (5) @(negedge clock);
      st.supply_on = 1'b1;
      repeat (3000) begin
         @(negedge clock);
         if (run === 1'b1) break;
      end
   endtask
   task automatic pulse(input int w);
      int g0;
      g0 = gate_cyc;
      req = 1'b1;
      repeat (w) @(negedge clock);
      req = 1'b0;
      repeat (30) @(negedge clock);
      last_on = gate_cyc - g0;
   endtask
   // Gate on-time of the last pulse against a window of cycles
   task automatic check_on(input int lo, input int hi);
      tests_run++;
      if (last_on < lo || last_on > hi) begin
         bad_count++;
         $display("wrong value gate on-time: expected %0d..%0d seen %0d", lo, hi, last_on);
      end
   endtask
   task automatic finish_test();
      $display("comparisons %0d mismatches %0d", tests_run, bad_count);
      if (bad_count == 0 && tests_run > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask
   initial begin
      {rst_n, req, ocp_en, ceil_en} = 4'h0;
      st = '0;
      b = '0;
      b.hvg_above_low = 1'b1;
      void'($urandom(47941));
      // A ceiling-cut pulse must not trip the first-pulse on-time check
      start_up(b);
      ceil_en = 1'b1;
      pulse(300);
      // Ceiling seen after 16 ramp cycles plus about five of sensing lag, then no re-fire
      check_on(16, 24);
      ceil_en = 1'b0;
      expect_out(3'b100, 3'b111);
      $display("test ceiling ended");
      // First-pulse on-time limit for each pin setting, just under and over
      for (int i = 0; i < 8; i++) begin
         b.cfg_high = i[0];
         b.rdm_large = i[1];
         lim = (i[0] | i[1]) ? ONT_LONG_CYC : ONT_SHORT_CYC;
         start_up(b);
         wid = i[2] ? lim + 10 + $urandom % 40 : lim - 20 - $urandom % 40;
         pulse(wid);
         expect_out(i[2] ? 3'b010 : 3'b100, 3'b111);
         check_on(i[2] ? lim + 1 : wid, i[2] ? lim + 1 : wid);
      end
      $display("test on-time ended");
      // A clean pulse breaks the over-current run; three in a row trip it
      b.cfg_high = 1'b0;
      b.rdm_large = 1'b0;
      start_up(b);
      for (int k = 0; k < 6; k++) begin
         ocp_en = (k != 2);
         pulse(40);
         check_on(40, 40);
         if (k == 4) expect_out(3'b100, 3'b111);
      end
      ocp_en = 1'b0;
      expect_out(3'b011, 3'b111);
      pulse(40);
      check_on(0, 0);
      expect_out(3'b011, 3'b111);
      $display("test over-current ended");
      // Run-time faults: heat, gate supply high, plain and shorted turn-off
      for (int k = 0; k < 5; k++) begin
         b.aux_below_min = (k == 3);
         b.cs_above_opp = (k == 4);
         start_up(b);
         // Over-power held far short of its full time must leave run standing
         expect_out(3'b100, 3'b111);
         st.over_temp = (k == 0);
         st.hvg_above_high = (k == 1);
         st.supply_off = (k >= 2);
         repeat (20) @(negedge clock);
         expect_out((k >= 3) ? 3'b011 : 3'b010, 3'b111);
      end
      $display("test run faults ended");
      // Faults present at turn-on keep the block out of run
      b = '0;
      for (int k = 0; k < 3; k++) begin
         b.hvg_above_low = (k != 1);
         b.pin_fault = (k == 0);
         b.over_temp = (k == 2);
         start_up(b);
         expect_out(3'b010, 3'b111);
      end
      $display("test turn-on faults ended");
      @(negedge clock);
      finish_test();
   end
endmodule
`default_nettype wire
